// *** rtl/aap_audio_port.v ***
// Full-duplex PCM codec audio port, device side
//
// Overview of operation
// - One full-duplex serial port sends and receives a sample each frame.
// - Exactly one codec is served; no shared multi-codec slots.
// - Stored config selects linear codec, log codec, or audio off.
// - Linear: 13-bit samples, 480 kHz bit clock, 8 kHz frame, 13-bit sync.
// - Log: 8-bit A-law samples, 120 kHz bit clock, 8 kHz frame, 14-bit sync.
// - Linear bit clock by integer division, below the ideal 512 kHz.
`timescale 1ns/1ps
`include "aap_consts.vh"
module aap_audio_port (
	clk,
	reset_n,
	cfg_mode,
	tx_sample,
	tx_take_r,
	rx_sample_r,
	rx_valid_r,
	active_r,
	pcm_bclk,
	pcm_fclk_r,
	pcm_fsync_r,
	pcm_dout_r,
	pcm_din
);
	input  wire        clk;
	input  wire        reset_n;
	input  wire [1:0]  cfg_mode;
	input  wire [12:0] tx_sample;
	output reg         tx_take_r;
	output reg  [12:0] rx_sample_r;
	output reg         rx_valid_r;
	output reg         active_r;
	output wire        pcm_bclk;
	output reg         pcm_fclk_r;
	output reg         pcm_fsync_r;
	output reg         pcm_dout_r;
	input  wire        pcm_din;

	// ************************************************
	// Timing constants
	// ************************************************
	// Integer forms first, then cut to width on purpose
	localparam integer LIN_HALF_I  = `AAP_LIN_HALF;
	localparam integer LOG_HALF_I  = `AAP_LOG_HALF;
	localparam integer LIN_FRAME_I = `AAP_LIN_FRAME;
	localparam integer LOG_FRAME_I = `AAP_LOG_FRAME;
	localparam integer LIN_BITS_I  = `AAP_LIN_BITS;
	localparam integer LOG_BITS_I  = `AAP_LOG_BITS;
	localparam integer LIN_SYNC_I  = `AAP_LIN_SYNC;
	localparam integer LOG_SYNC_I  = `AAP_LOG_SYNC;

	localparam [7:0] LIN_HALF  = LIN_HALF_I[7:0];
	localparam [7:0] LOG_HALF  = LOG_HALF_I[7:0];
	localparam [6:0] LIN_FRAME = LIN_FRAME_I[6:0];
	localparam [6:0] LOG_FRAME = LOG_FRAME_I[6:0];
	localparam [6:0] LIN_BITS  = LIN_BITS_I[6:0];
	localparam [6:0] LOG_BITS  = LOG_BITS_I[6:0];
	localparam [6:0] LIN_SYNC  = LIN_SYNC_I[6:0];
	localparam [6:0] LOG_SYNC  = LOG_SYNC_I[6:0];
	localparam [6:0] IDX_IDLE  = `AAP_IDX_IDLE;

	reg  [1:0]  cfg_r;
	reg  [1:0]  mode_r;
	reg  [6:0]  idx_r;
	reg  [12:0] tx_sh_r;
	reg  [12:0] rx_sh_r;
	reg         din_s1_r;
	reg         din_s2_r;

	wire        run;
	wire        is_log;
	wire [7:0]  half_cnt;
	wire [6:0]  frame_bits;
	wire [6:0]  word_bits;
	wire [6:0]  sync_bits;
	wire [6:0]  idx_nxt;
	wire [12:0] tx_word;
	wire [12:0] rx_nxt;
	wire        rise;
	wire        fall;
	wire        frame_end;
	wire        last_bit;

	// ************************************************
	// Mode parameters
	// ************************************************
	assign run        = (mode_r != `AAP_MODE_OFF);
	assign is_log     = (mode_r == `AAP_MODE_LOG);
	assign half_cnt   = is_log ? LOG_HALF : LIN_HALF;
	assign frame_bits = is_log ? LOG_FRAME : LIN_FRAME;
	assign word_bits  = is_log ? LOG_BITS : LIN_BITS;
	assign sync_bits  = is_log ? LOG_SYNC : LIN_SYNC;

	// ************************************************
	// Frame position
	// ************************************************
	// Idle index restarts the count at the next rise
	assign idx_nxt    = (idx_r == IDX_IDLE || idx_r == frame_bits - 7'h01) ?
	                    7'h00 : idx_r + 7'h01;
	// Last falling edge of a frame: the safe point for a mode change
	assign frame_end  = fall && (idx_r == frame_bits - 7'h01);
	// Falling edge that samples the last word bit
	assign last_bit   = fall && (idx_r == word_bits - 7'h01);
	// Log word left-justified so its MSB leaves first
	assign tx_word    = is_log ? {tx_sample[7:0], 5'h00} : tx_sample;
	assign rx_nxt     = {rx_sh_r[11:0], din_s2_r};

	// ************************************************
	// Bit clock divider
	// ************************************************
	// Whole clocks per half period only: bit rates are approximate
	aap_bclk_gen #(
		.CW       (8)
	) u_bclk (
		.clk      (clk),
		.reset_n  (reset_n),
		.run      (run),
		.half_cnt (half_cnt),
		.bclk_r   (pcm_bclk),
		.rise_r   (rise),
		.fall_r   (fall)
	);

	// ************************************************
	// Input synchroniser
	// ************************************************
	// Only the second stage feeds the receiver
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			din_s1_r <= 1'b0;
			din_s2_r <= 1'b0;
		end else begin
			din_s1_r <= pcm_din;
			din_s2_r <= din_s1_r;
		end
	end

	// ************************************************
	// Mode selection, applied only between frames
	// ************************************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r    <= `AAP_MODE_OFF;
			mode_r   <= `AAP_MODE_OFF;
			active_r <= 1'b0;
		end else begin
			// Unknown codes treated as audio off
			cfg_r <= (cfg_mode == `AAP_MODE_LIN || cfg_mode == `AAP_MODE_LOG) ?
			         cfg_mode : `AAP_MODE_OFF;
			// Off, or at a frame boundary: the new path takes over
			if (!run || frame_end) begin
				mode_r   <= cfg_r;
				active_r <= (cfg_r != `AAP_MODE_OFF);
			end
		end
	end

	// ************************************************
	// Transmit side and frame timing, on rising edges
	// ************************************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_r       <= IDX_IDLE;
			tx_sh_r     <= 13'h0000;
			tx_take_r   <= 1'b0;
			pcm_fclk_r  <= 1'b0;
			pcm_fsync_r <= 1'b0;
			pcm_dout_r  <= 1'b0;
		end else begin
			tx_take_r <= 1'b0;
			if (!run) begin
				// Audio off: link pins rest low
				idx_r       <= IDX_IDLE;
				pcm_fclk_r  <= 1'b0;
				pcm_fsync_r <= 1'b0;
				pcm_dout_r  <= 1'b0;
			end else if (frame_end && cfg_r != mode_r) begin
				// Mode change: next frame restarts cleanly
				idx_r <= IDX_IDLE;
			end else if (rise) begin
				idx_r       <= idx_nxt;
				pcm_fsync_r <= (idx_nxt < sync_bits);
				pcm_fclk_r  <= (idx_nxt < {1'b0, frame_bits[6:1]});
				// Word captured at frame start; user has a frame to refresh it
				if (idx_nxt == 7'h00) begin
					pcm_dout_r <= tx_word[12];
					tx_sh_r    <= {tx_word[11:0], 1'b0};
					tx_take_r  <= 1'b1;
				end else if (idx_nxt < word_bits) begin
					pcm_dout_r <= tx_sh_r[12];
					tx_sh_r    <= {tx_sh_r[11:0], 1'b0};
				end else begin
					pcm_dout_r <= 1'b0;
				end
			end
		end
	end

	// ************************************************
	// Receive side, sampled on falling edges
	// ************************************************
	// Two flops of delay still leave most of half a bit of setup
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_sh_r     <= 13'h0000;
			rx_sample_r <= 13'h0000;
			rx_valid_r  <= 1'b0;
		end else begin
			rx_valid_r <= 1'b0;
			if (run && fall && idx_r < word_bits) begin
				rx_sh_r <= rx_nxt;
				if (last_bit) begin
					// Log byte lands in the low bits
					rx_sample_r <= is_log ? {5'h00, rx_nxt[7:0]} : rx_nxt;
					rx_valid_r  <= 1'b1;
				end
			end
		end
	end
	// Single codec only: one sync, one data pair per frame
endmodule

// *** rtl/aap_bclk_gen.v ***
// Bit clock divider with edge pulses
`timescale 1ns/1ps
module aap_bclk_gen #(
	parameter CW = 8
) (
	clk,
	reset_n,
	run,
	half_cnt,
	bclk_r,
	rise_r,
	fall_r
);
	input  wire          clk;
	input  wire          reset_n;
	input  wire          run;
	input  wire [CW-1:0] half_cnt;
	output reg           bclk_r;
	output reg           rise_r;
	output reg           fall_r;

	reg [CW-1:0] cnt_r;

	// ************************************************
	// Integer divider: toggles every half_cnt clocks
	// ************************************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r  <= {CW{1'b0}};
			bclk_r <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else if (!run) begin
			cnt_r  <= {CW{1'b0}};
			bclk_r <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else if (cnt_r >= half_cnt - {{(CW-1){1'b0}}, 1'b1}) begin
			cnt_r  <= {CW{1'b0}};
			bclk_r <= ~bclk_r;
			rise_r <= ~bclk_r;
			fall_r <= bclk_r;
		end else begin
			cnt_r  <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end
	end
endmodule

// *** rtl/aap_consts.vh ***
// Constants for the PCM codec audio port
`ifndef AAP_CONSTS_VH
`define AAP_CONSTS_VH

// System clock rate
`define AAP_CLK_HZ        25000000
// Ideal linear bit clock, not reachable through integer division
`define AAP_BCLK_IDEAL_HZ 512000
// Nominal bit clock and frame clock rates; integer halves make the real rates slightly higher
`define AAP_BCLK_LIN_HZ   480000
`define AAP_BCLK_LOG_HZ   120000
`define AAP_FCLK_HZ       8000

// Half bit periods in system clocks, rounded down by integer division
`define AAP_LIN_HALF      (`AAP_CLK_HZ / (2 * `AAP_BCLK_LIN_HZ))
`define AAP_LOG_HALF      (`AAP_CLK_HZ / (2 * `AAP_BCLK_LOG_HZ))

// Bit periods per frame
`define AAP_LIN_FRAME     (`AAP_BCLK_LIN_HZ / `AAP_FCLK_HZ)
`define AAP_LOG_FRAME     (`AAP_BCLK_LOG_HZ / `AAP_FCLK_HZ)

// Sample word widths and frame sync lengths in bit periods
`define AAP_LIN_BITS      13
`define AAP_LOG_BITS      8
`define AAP_LIN_SYNC      13
`define AAP_LOG_SYNC      14

// Audio path selection codes from stored config memory
`define AAP_MODE_OFF      2'h0
`define AAP_MODE_LIN      2'h1
`define AAP_MODE_LOG      2'h2

// Bit index while no frame is running
`define AAP_IDX_IDLE      7'h7F

`endif

// *** verification/aap_audio_port_bench.sv ***
// Self-checking bench for the PCM codec audio port
`timescale 1ns/1ps
module aap_audio_port_bench;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [1:0]  cfg_mode = 2'h0;
	logic [12:0] tx_sample = 13'h0;
	logic [12:0] word = 13'h0;
	logic [3:0]  nbits = 4'hD;
	wire         tx_take_r, rx_valid_r, active_r, pcm_bclk, pcm_fclk_r;
	wire         pcm_fsync_r, pcm_dout_r, pcm_din;
	wire  [12:0] rx_sample_r, got;
	wire  [2:0]  ev = {~active_r, rx_valid_r, tx_take_r};
	wire  [6:0]  flags = {tx_take_r, rx_valid_r, active_r, pcm_bclk, pcm_fclk_r, pcm_fsync_r,
		pcm_dout_r};
	int          n_mismatch = 0;
	int          num_checks = 0;
	always #20 clk = ~clk;
	aap_audio_port dut (.clk, .reset_n, .cfg_mode, .tx_sample, .tx_take_r, .rx_sample_r,
		.rx_valid_r, .active_r, .pcm_bclk, .pcm_fclk_r, .pcm_fsync_r, .pcm_dout_r, .pcm_din);
	aap_codec_model codec (.pcm_bclk, .pcm_fsync_r, .pcm_dout_r, .nbits, .word, .pcm_din,
		.got);
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp(input logic [12:0] a, input logic [12:0] e);
		num_checks++;
		if (a !== e) begin
			n_mismatch++;
			$display("wrong value t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask
	// Event 0 take, 1 receive, 2 idle
	task wait_on(input int k);
		int n;
		for (n = 0; n < 9000; n++) begin
			@(posedge clk);
			#1;
			if (ev[k] === 1'b1)
				return;
		end
		n_mismatch++;
		end_of_test;
	endtask
	task run_mode(input logic [1:0] m, input logic [3:0] n, input logic [12:0] tx,
		input logic [12:0] w, input logic [12:0] eg);
		@(posedge clk);
		cfg_mode <= m;
		tx_sample <= tx;
		nbits <= n;
		word <= w;
		wait_on(0);
		wait_on(1);
		cmp(rx_sample_r, w);
		cmp(got, eg);
	endtask
	task off_check(input logic [1:0] m);
		@(posedge clk);
		cfg_mode <= m;
		wait_on(2);
		repeat (300) @(posedge clk);
		#1;
		cmp({10'h0, active_r, pcm_bclk, pcm_fsync_r}, 13'h0);
	endtask
	// Reset in mid-run: outputs drop, path restarts two edges after release
	task reset_mid;
		repeat (40) @(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		#1;
		cmp({6'h00, flags}, 13'h0000);
		cmp(rx_sample_r, 13'h0000);
		@(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		#1;
		cmp({12'h000, active_r}, 13'h0000);
		@(posedge clk);
		#1;
		cmp({12'h000, active_r}, 13'h0001);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		run_mode(2'h1, 4'hD, 13'h1A5C, 13'h0B37, 13'h1A5C);
		reset_mid;
		run_mode(2'h1, 4'hD, 13'h0001, 13'h1000, 13'h0001);
		off_check(2'h3);
		off_check(2'h0);
		run_mode(2'h2, 4'h8, 13'h1FA5, 13'h003C, 13'h00A5);
		run_mode(2'h2, 4'h8, 13'h0080, 13'h00FE, 13'h0080);
		off_check(2'h0);
		end_of_test;
	end
endmodule

// *** verification/aap_codec_model.sv ***
// Behavioural codec on the far side of the audio link
`timescale 1ns/1ps
module aap_codec_model (
	input  wire         pcm_bclk,
	input  wire         pcm_fsync_r,
	input  wire         pcm_dout_r,
	input  wire  [3:0]  nbits,
	input  wire  [12:0] word,
	output logic        pcm_din,
	output logic [12:0] got
);
	int   i = 99;
	logic bclk_q = 1'b0;
	logic fs_q = 1'b0;
	// One process owns every output: sync start, drive on rise, sample on fall
	initial begin
		pcm_din = 1'b0;
		got = 13'h0;
		forever begin
			@(pcm_bclk or pcm_fsync_r);
			if (pcm_fsync_r && !fs_q) begin
				// Word starts with the sync pulse, MSB first
				i = nbits - 1;
				got = 13'h0;
				pcm_din = word[i];
			end else if (pcm_bclk && !bclk_q) begin
				if (i > 0 && i < nbits) begin
					i = i - 1;
					pcm_din = word[i];
				end else begin
					// Idle line keeps toggling
					i = 99;
					pcm_din = ~pcm_din;
				end
			end else if (!pcm_bclk && bclk_q && i < nbits) begin
				got[i] = pcm_dout_r;
			end
			bclk_q = pcm_bclk;
			fs_q = pcm_fsync_r;
		end
	end
endmodule

// *** verification/aap_port_monitor.sv ***
// Checker for the PCM codec audio port
`timescale 1ns/1ps
module aap_port_monitor (
	input wire       clk,
	input wire       reset_n,
	input wire [1:0] cfg_mode,
	input wire       tx_take_r,
	input wire       rx_valid_r,
	input wire       active_r,
	input wire       pcm_bclk,
	input wire       pcm_fclk_r,
	input wire       pcm_fsync_r,
	input wire       pcm_dout_r
);
	logic [11:0] run_r;
	logic [11:0] fs_r;
	logic [11:0] fp_r;
	logic [11:0] fc_r;
	logic        seen_r;
	// Cycles since bclk toggled, sync high time, frame spacing
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_r <= 12'h0;
			fs_r <= 12'h0;
			fp_r <= 12'hFFF;
			fc_r <= 12'h0;
			seen_r <= 1'b0;
		end else begin
			run_r <= $changed(pcm_bclk) ? 12'h0 : run_r + 12'h1;
			fs_r <= pcm_fsync_r ? fs_r + 12'h1 : 12'h0;
			fc_r <= pcm_fclk_r ? fc_r + 12'h1 : 12'h0;
			seen_r <= active_r && (seen_r || $changed(pcm_bclk));
			if (!active_r || $rose(pcm_fsync_r))
				fp_r <= active_r ? 12'h0 : 12'hFFF;
			else if (fp_r != 12'hFFF)
				fp_r <= fp_r + 12'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_off_quiet: assert property (!active_r [*2] |-> !pcm_bclk && !pcm_fsync_r)
		else $error("link busy while off");
	chk_take_active: assert property (tx_take_r |-> active_r)
		else $error("take while off");
	chk_frame_start: assert property ($rose(pcm_fsync_r) |-> tx_take_r && pcm_fclk_r)
		else $error("frame start mismatch");
	chk_lin_half: assert property ($changed(pcm_bclk) && seen_r && cfg_mode == 2'h1
		|-> run_r == 12'd25) else $error("linear half period");
	chk_log_half: assert property ($changed(pcm_bclk) && seen_r && cfg_mode == 2'h2
		|-> run_r == 12'd103) else $error("log half period");
	chk_sync_len: assert property ($fell(pcm_fsync_r) && ^cfg_mode
		|-> fs_r == (cfg_mode == 2'h1 ? 12'd676 : 12'd2912)) else $error("sync length");
	chk_frame_rate: assert property ($rose(pcm_fsync_r) && fp_r != 12'hFFF
		|-> fp_r == 12'd3119) else $error("frame period");
	chk_fclk_len: assert property ($fell(pcm_fclk_r) && ^cfg_mode
		|-> fc_r == (cfg_mode == 2'h1 ? 12'd1560 : 12'd1456)) else $error("frame clock high time");
	chk_dout_idle: assert property (!pcm_fsync_r |-> !pcm_dout_r)
		else $error("data outside word");
	chk_dout_edge: assert property ($changed(pcm_dout_r)
		|-> $past(pcm_bclk) && !$past(pcm_bclk, 2)) else $error("data off rising edge");
	chk_valid_pulse: assert property (rx_valid_r |=> !rx_valid_r [*8])
		else $error("receive pulse too long");
	cover property ($rose(pcm_fsync_r) && cfg_mode == 2'h1);
	cover property ($rose(pcm_fsync_r) && cfg_mode == 2'h2);
	cover property (rx_valid_r);
endmodule
bind aap_audio_port aap_port_monitor mon (.clk, .reset_n, .cfg_mode, .tx_take_r,
	.rx_valid_r, .active_r, .pcm_bclk, .pcm_fclk_r, .pcm_fsync_r, .pcm_dout_r);
